// file: rtl/erd_timers.v
// Event response delay timers with AXI4-Lite register access
// How it works
// - Bit 15 set in a delay setting suppresses that condition's action entirely.
// - Velocity following error has its own 16-bit delay word at index 4.
// - Positive velocity limit has its own delay word at index 5.
// - Negative velocity limit has its own delay word at index 6.
`timescale 1ns/1ps
`include "erd_regs.vh"
module erd_timers #(
  parameter N = 9,
  parameter TICK_CYCLES = `ERD_TICK_CYCLES
) (
  input wire clk_i,
  input wire rst_i,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [N-1:0] cond_i,
  output reg [N-1:0] action_o,
  output reg nvm_we_o,
  output reg [3:0] nvm_addr_o,
  output reg [15:0] nvm_data_o,
  input wire nvm_load_i,
  input wire [3:0] nvm_load_addr_i,
  input wire [15:0] nvm_load_data_i,
  output wire irq_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data latched in either order
  reg aw_full_reg;
  reg w_full_reg;
  reg [7:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  reg [N-1:0] stat_reg;
  reg [N-1:0] en_reg;
  reg [N-1:0] clr_pulse;
  reg [15:0] shadow_reg [0:N-1];
  wire do_write;
  wire [7:0] wa;
  wire [5:0] widx;
  wire dly_hit;
  wire [15:0] wmerged;
  assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_full_reg && !s_axi_bvalid;
  assign do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
  assign wa = aw_addr_reg;
  assign widx = wa[7:2];
  assign dly_hit = (wa[1:0] == 2'b00) && (widx < N);
  assign wmerged = {w_strb_reg[1] ? w_data_reg[15:8] : shadow_reg[widx[3:0]][15:8],
                    w_strb_reg[0] ? w_data_reg[7:0] : shadow_reg[widx[3:0]][7:0]};
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ERD_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (dly_hit || wa == `ERD_CLR_ADDR || wa == `ERD_EN_ADDR || wa == `ERD_STAT_ADDR) begin
          s_axi_bresp <= `ERD_RESP_OKAY;
        end else begin
          s_axi_bresp <= `ERD_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Delay settings: shadow copy steers timers, memory serves reads
  wire mem_we;
  wire [3:0] mem_waddr;
  wire [15:0] mem_wdata;
  wire [15:0] mem_rdata;
  reg [3:0] mem_raddr;
  assign mem_we = (do_write && dly_hit) || nvm_load_i;
  assign mem_waddr = nvm_load_i ? nvm_load_addr_i : widx[3:0];
  assign mem_wdata = nvm_load_i ? nvm_load_data_i : wmerged;
  erd_delay_mem #(
    .DEPTH(N),
    .AW(4)
  ) u_mem (
    .clk_i(clk_i),
    .we_i(mem_we),
    .waddr_i(mem_waddr),
    .wdata_i(mem_wdata),
    .raddr_i(mem_raddr),
    .rdata_o(mem_rdata)
  );
  // Software write to a delay word in a cycle without nvm_load_i is pushed to storage so it survives power cycles
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      nvm_we_o <= 1'b0;
      nvm_addr_o <= 4'h0;
      nvm_data_o <= 16'h0000;
    end else begin
      nvm_we_o <= do_write && dly_hit && !nvm_load_i;
      nvm_addr_o <= widx[3:0];
      nvm_data_o <= wmerged;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Millisecond time base
  reg [31:0] tick_cnt_reg;
  wire ms_tick;
  assign ms_tick = (tick_cnt_reg == TICK_CYCLES - 1);
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_cnt_reg <= 32'h0000_0000;
    end else if (ms_tick) begin
      tick_cnt_reg <= 32'h0000_0000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Per-condition timers; shadow index 4,5,6 are vel-follow, +vel, -vel limits
  wire [N-1:0] done;
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_tmr
      reg [15:0] cnt_reg;
      reg busy_reg;
      reg cond_d_reg;
      wire rise;
      wire [15:0] dly;
      wire [15:0] target;
      assign dly = shadow_reg[g];
      assign rise = cond_i[g] && !cond_d_reg;
      // The tick runs free, so the first tick after the rise is only a partial millisecond.
      // One extra tick makes the wait at least the programmed time, at most one ms more.
      assign target = {1'b0, dly[14:0]} + {15'h0000, |dly[14:0]};
      // A condition that is gone in the final cycle must not fire either
      assign done[g] = busy_reg && cond_i[g] && (cnt_reg == target) && !dly[`ERD_DIS_BIT];
      always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          shadow_reg[g] <= `ERD_DLY_RESET;
        end else if (mem_we && mem_waddr == g) begin
          shadow_reg[g] <= mem_wdata;
        end
      end
      always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          cnt_reg <= 16'h0000;
          busy_reg <= 1'b0;
          cond_d_reg <= 1'b0;
          action_o[g] <= 1'b0;
        end else begin
          cond_d_reg <= cond_i[g];
          action_o[g] <= done[g];
          // A condition that goes away before the delay ends cancels the action
          if (rise && !dly[`ERD_DIS_BIT]) begin
            busy_reg <= 1'b1;
            cnt_reg <= 16'h0000;
          end else if (!cond_i[g] || done[g] || dly[`ERD_DIS_BIT]) begin
            busy_reg <= 1'b0;
          end else if (busy_reg && ms_tick) begin
            cnt_reg <= cnt_reg + 16'h0001;
          end
        end
      end
      // Sticky status: a new event wins over a clear in the same cycle
      always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          stat_reg[g] <= 1'b0;
        end else if (done[g]) begin
          stat_reg[g] <= 1'b1;
        end else if (clr_pulse[g]) begin
          stat_reg[g] <= 1'b0;
        end
      end
    end
  endgenerate
  always @* begin
    clr_pulse = {N{1'b0}};
    if (do_write && wa == `ERD_CLR_ADDR) begin
      clr_pulse = w_data_reg[N-1:0];
    end
  end
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_reg <= {N{1'b0}};
    end else if (do_write && wa == `ERD_EN_ADDR) begin
      en_reg <= w_data_reg[N-1:0];
    end
  end
  assign irq_o = |(stat_reg & en_reg);
  ////////////////////////////////////////////////////////////////////////////
  // Read channel: one-hot sequencer, answer two cycles after the address is taken
  // The memory sees the bus address at once, so its registered data are ready one edge later
  localparam RD_IDLE = 3'b001;
  localparam RD_FETCH = 3'b010;
  localparam RD_ANSWER = 3'b100;
  reg [2:0] rd_state_reg;
  reg [2:0] rd_state_next;
  reg [7:0] ar_addr_reg;
  reg [7:0] ar_addr_next;
  reg [31:0] rdata_next;
  reg [1:0] rresp_next;
  reg rvalid_next;
  wire rd_dly_hit;
  assign s_axi_arready = rd_state_reg[0];
  assign rd_dly_hit = (ar_addr_reg[1:0] == 2'b00) && (ar_addr_reg[7:2] < N);
  always @* begin
    mem_raddr = s_axi_araddr[5:2];
  end
  always @* begin
    rd_state_next = rd_state_reg;
    ar_addr_next = ar_addr_reg;
    rdata_next = s_axi_rdata;
    rresp_next = s_axi_rresp;
    rvalid_next = s_axi_rvalid;
    case (rd_state_reg)
      RD_IDLE: begin
        if (s_axi_arvalid) begin
          ar_addr_next = s_axi_araddr;
          rd_state_next = RD_FETCH;
        end
      end
      RD_FETCH: begin
        rd_state_next = RD_ANSWER;
        rvalid_next = 1'b1;
        rresp_next = `ERD_RESP_OKAY;
        rdata_next = 32'h0000_0000;
        if (rd_dly_hit) begin
          rdata_next = {16'h0000, mem_rdata};
        end else if (ar_addr_reg == `ERD_STAT_ADDR) begin
          rdata_next[N-1:0] = stat_reg;
        end else if (ar_addr_reg == `ERD_EN_ADDR) begin
          rdata_next[N-1:0] = en_reg;
        end else if (ar_addr_reg != `ERD_CLR_ADDR) begin
          rresp_next = `ERD_RESP_SLVERR;
        end
      end
      RD_ANSWER: begin
        // Data stand unchanged until the master takes them
        if (s_axi_rready) begin
          rvalid_next = 1'b0;
          rd_state_next = RD_IDLE;
        end
      end
      default: begin
        rd_state_next = RD_IDLE;
        rvalid_next = 1'b0;
      end
    endcase
  end
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_state_reg <= RD_IDLE;
      ar_addr_reg <= 8'h00;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `ERD_RESP_OKAY;
    end else begin
      rd_state_reg <= rd_state_next;
      ar_addr_reg <= ar_addr_next;
      s_axi_rvalid <= rvalid_next;
      s_axi_rdata <= rdata_next;
      s_axi_rresp <= rresp_next;
    end
  end
endmodule // erd_timers

// file: pkg/erd_regs.vh
// Register map, field positions and timing constants of the event response delay timers
`ifndef ERD_REGS_VH
`define ERD_REGS_VH
`define ERD_NUM_EVT 9
`define ERD_DLY_BASE 8'h00
`define ERD_STAT_ADDR 8'h40
`define ERD_CLR_ADDR 8'h44
`define ERD_EN_ADDR 8'h48
`define ERD_NVM_ADDR 8'h4C
`define ERD_DIS_BIT 15
`define ERD_DLY_RESET 16'h0000
`define ERD_CLK_HZ 20000000
`define ERD_MS_PER_S 1000
`define ERD_TICK_CYCLES (`ERD_CLK_HZ / `ERD_MS_PER_S)
`define ERD_RESP_OKAY 2'b00
`define ERD_RESP_SLVERR 2'b10
`endif

// file: rtl/erd_delay_mem.v
// Small delay-setting memory with registered read data
`timescale 1ns/1ps
module erd_delay_mem #(
  parameter DEPTH = 9,
  parameter AW = 4
) (
  input wire clk_i,
  input wire we_i,
  input wire [AW-1:0] waddr_i,
  input wire [15:0] wdata_i,
  input wire [AW-1:0] raddr_i,
  output reg [15:0] rdata_o
);
  reg [15:0] mem_reg [0:DEPTH-1];
  // No reset: contents are restored from non-volatile storage after power-up
  always @(posedge clk_i) begin
    if (we_i) begin
      mem_reg[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_reg[raddr_i];
  end
endmodule // erd_delay_mem

// file: sim/erd_timers_monitor.sv
// Assertion checker for the event response delay timers
`timescale 1ns/1ps
module erd_timers_monitor #(
  parameter N = 9
) (
  input wire clk_i,
  input wire rst_i,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [N-1:0] cond_i,
  input wire [N-1:0] action_o,
  input wire nvm_we_o,
  input wire [3:0] nvm_addr_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////
  // An action needs its condition held for at least the two detect cycles
  property p_act_cause;
    |action_o |-> (action_o & $past(cond_i) & $past(cond_i, 2)) == action_o;
  endproperty
  a_act_cause: assert property (p_act_cause) else $error("action without held condition");
  property p_act_pulse;
    |action_o |=> ~|(action_o & $past(action_o));
  endproperty
  a_act_pulse: assert property (p_act_pulse) else $error("action longer than one cycle");
  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |=> !s_axi_rvalid ##1 s_axi_rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer not two cycles late");
  property p_rd_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read answer dropped");
  property p_wr_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write answer dropped");
  property p_wr_resp;
    s_axi_awvalid && s_axi_awready |-> ##[1:8] s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write answer missing");
  property p_nvm_addr;
    nvm_we_o |-> nvm_addr_o < N;
  endproperty
  a_nvm_addr: assert property (p_nvm_addr) else $error("storage address out of range");
  property p_aw_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_aw_block: assert property (p_aw_block) else $error("write taken during answer");
  c_act: cover property (action_o[5]);
  c_nvm: cover property (nvm_we_o);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
endmodule // erd_timers_monitor

bind erd_timers erd_timers_monitor #(.N(N)) i_mon (.*);

// file: sim/tb_top.sv
// Self-checking bench for the event response delay timers
`timescale 1ns/1ps
`include "erd_regs.vh"
module tb_top;
  // Short millisecond tick keeps the timer waits to a few cycles
  localparam T = 4;
  logic clk_i = 0, rst_i = 1;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF, nvm_addr_o, nvm_load_addr_i = 0, la_q;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, nvm_we_o, irq_o;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [8:0] cond_i = 0, action_o;
  logic nvm_load_i = 0;
  logic [15:0] nvm_load_data_i = 0, nvm_data_o, ld_q;
  int n_errors = 0, num_checks = 0, cyc = 0;
  erd_timers #(.TICK_CYCLES(T)) i_dut (.*);
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (nvm_we_o) begin
      la_q <= nvm_addr_o;
      ld_q <= nvm_data_o;
    end
    if (cyc == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do @(negedge clk_i); while (!(s_axi_awready && s_axi_wready));
    @(posedge clk_i);
    s_axi_awvalid <= 0;
    s_axi_wvalid <= 0;
    do @(negedge clk_i); while (!s_axi_bvalid);
    chk("bresp", er, s_axi_bresp);
    @(posedge clk_i);
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(negedge clk_i); while (!s_axi_arready);
    @(posedge clk_i);
    s_axi_arvalid <= 0;
    do @(negedge clk_i); while (!s_axi_rvalid);
    chk("rdata", e, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
    @(posedge clk_i);
    s_axi_rready <= 0;
  endtask
  // Condition is held through the whole wait; dropping it would cancel the timer
  task automatic fire(input int i, input logic [15:0] d, input logic [8:0] en);
    int n;
    wr(`ERD_EN_ADDR, {23'h0, en}, `ERD_RESP_OKAY);
    wr(i * 4, {16'h0, d}, `ERD_RESP_OKAY);
    @(posedge clk_i);
    cond_i[i] <= 1;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (!action_o[i] && n < 300);
    if (d[15]) chk("no action", 300, n);
    else chk("wait in range", 1, n >= d * T + 1 && n <= d * T + T + 3);
    rd(`ERD_STAT_ADDR, d[15] ? 0 : 1 << i, `ERD_RESP_OKAY);
    chk("irq", !d[15] && en[i], irq_o);
    @(posedge clk_i);
    cond_i[i] <= 0;
    wr(`ERD_CLR_ADDR, 32'h0000_01FF, `ERD_RESP_OKAY);
    rd(`ERD_STAT_ADDR, 0, `ERD_RESP_OKAY);
    chk("irq clear", 0, irq_o);
  endtask
  task automatic s_regs();
    for (int i = 0; i < 9; i++) begin
      wr(i * 4, {16'hFFFF, 16'h1000 + i[15:0]}, `ERD_RESP_OKAY);
      rd(i * 4, 32'h0000_1000 + i, `ERD_RESP_OKAY);
      chk("nvm copy", {i[3:0], 16'h1000 + i[15:0]}, {la_q, ld_q});
    end
    wr(`ERD_NVM_ADDR, 1, `ERD_RESP_SLVERR);
    rd(`ERD_NVM_ADDR, 0, `ERD_RESP_SLVERR);
    @(posedge clk_i);
    nvm_load_addr_i <= 7;
    nvm_load_data_i <= 16'h0123;
    nvm_load_i <= 1;
    @(posedge clk_i);
    nvm_load_i <= 0;
    rd(8'h1C, 32'h0000_0123, `ERD_RESP_OKAY);
  endtask
  task automatic tally_and_finish();
    if (n_errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    s_regs();
    fire(4, 16'd3, 9'h1FF);
    fire(5, 16'd0, 9'h1FF);
    fire(6, 16'd2, 9'h000);
    fire(0, 16'h8001, 9'h1FF);
    fire(8, 16'd1, 9'h100);
    tally_and_finish();
  end
endmodule // tb_top
